// File: verilog/plc_config_regs.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Contract
// - Status LED select 00 charger, 01 blink, 10 off, 11 on.
// - Status LED period field, 100 ms per count, at least 100 ms.
// - Status LED on-time field, 10 ms per count, at least 10 ms.
// - Aux LED select 00 off, 01 blink, 10 off, 11 on.
// - Aux LED on-time field, 10 ms per count, at least 10 ms.
// - Aux LED period field, 100 ms per count, at least 100 ms.
// - Fixed-frequency bit forces both converters to PWM at light load.
// - Two bits choose the brownout threshold among four levels.
// - Active sleep pin enters wait if kind bit 0, low-power if 1.
// - Sleep pin is ignored unless its enable bit is set.
// - Peripheral rail discharged when disabled and discharge bit set.
// - Peripheral rail voltage from two bits; low bit strapped at reset.
// - Proc rail off in low-power mode when its off bit set.
// - Three-bit proc rail code selects one of eight voltages.
// - Low bit of proc rail code loaded from strap at reset.
// - Low-power uses proc code with top bit zero, lower from sleep bits.
// - Motor switch follows its control bit.
// - Proc rail discharged when off (wait, or low-power with rail-off bit) and discharge bit set.
// - Regulator enable and sleep-off decode full, reduced or off.
// - Second regulator voltage from bits 5 and 4.
// - First regulator voltage from bits 1 and 0.
// - Regulator voltage code accepted while disabled or in the enabling write.
module plc_config_regs #(
  parameter int TICK_LEN = plc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // Register port from the serial interface
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Pins
  input wire logic SLEEP_REQUEST_PIN,
  input wire logic PERIPH_VOLT_STRAP,
  input wire logic PROC_VOLT_STRAP,
  input wire logic CHG_LED_REQ,
  // Open-drain LED pins
  input wire logic STATUS_LED_OUTPUT_I,
  output logic STATUS_LED_OUTPUT_O,
  output logic STATUS_LED_OUTPUT_OE,
  input wire logic AUX_LED_OUTPUT_I,
  output logic AUX_LED_OUTPUT_O,
  output logic AUX_LED_OUTPUT_OE,
  // Converter controls
  output logic FIXED_FREQ_FORCE,
  output logic [1:0] BROWNOUT_LEVEL,
  output logic WAIT_MODE,
  output logic LOW_POWER_MODE,
  output logic PERIPH_RAIL_EN,
  output logic PERIPH_RAIL_DISCHARGE,
  output logic [1:0] PERIPH_RAIL_VOLT,
  output logic PROC_RAIL_EN,
  output logic PROC_RAIL_DISCHARGE,
  output logic [2:0] PROC_RAIL_VOLT,
  output logic MOTOR_BUZZ_SWITCH,
  // Linear regulator controls
  output logic REG1_EN,
  output logic REG1_REDUCED,
  output logic [1:0] REG1_VOLT,
  output logic REG2_EN,
  output logic REG2_REDUCED,
  output logic [1:0] REG2_VOLT
);
  import plc_pkg::*;

  logic [7:0] led_on_r [2];
  logic [7:0] led_per_r [2];
  logic [7:0] periph_cfg_r;
  logic [7:0] proc_cfg_r;
  logic [7:0] linear_cfg_r;
  logic [7:0] linear_nxt;
  logic [7:0] rdata_nxt;
  logic sleep_s1_r, sleep_s2_r;
  logic pstrap_s1_r, pstrap_s2_r;
  logic cstrap_s1_r, cstrap_s2_r;
  logic [1:0] strap_cnt_r;
  logic strap_load;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [10:0] pos_r [2];
  logic [1:0] sel [2];
  logic [1:0] wr_led_on, wr_led_per;
  logic sleep_active, wait_mode, lp_mode, proc_off;
  logic drive [2];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      pstrap_s1_r <= 1'b0;
      pstrap_s2_r <= 1'b0;
      cstrap_s1_r <= 1'b0;
      cstrap_s2_r <= 1'b0;
    end
    else
    begin
      sleep_s1_r <= SLEEP_REQUEST_PIN;
      sleep_s2_r <= sleep_s1_r;
      pstrap_s1_r <= PERIPH_VOLT_STRAP;
      pstrap_s2_r <= pstrap_s1_r;
      cstrap_s1_r <= PROC_VOLT_STRAP;
      cstrap_s2_r <= cstrap_s1_r;
    end
  end

  // Straps are taken once the synchronisers hold post-reset pin levels
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      strap_cnt_r <= 2'h0;
    else if (strap_cnt_r != STRAP_SETTLE)
      strap_cnt_r <= strap_cnt_r + 2'h1;
  end

  assign strap_load = (strap_cnt_r == STRAP_SETTLE - 2'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  assign wr_led_on[0] = REG_WR && REG_ADDR == STATUS_LED_ON_TIME_ADDR;
  assign wr_led_per[0] = REG_WR && REG_ADDR == STATUS_LED_PERIOD_ADDR;
  assign wr_led_on[1] = REG_WR && REG_ADDR == AUX_LED_ON_TIME_ADDR;
  assign wr_led_per[1] = REG_WR && REG_ADDR == AUX_LED_PERIOD_ADDR;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      led_on_r[0] <= LED_REG_RST;
      led_on_r[1] <= LED_REG_RST;
      led_per_r[0] <= LED_REG_RST;
      led_per_r[1] <= LED_REG_RST;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_led_on[i])
          led_on_r[i] <= REG_WDATA;
        if (wr_led_per[i])
          led_per_r[i] <= REG_WDATA;
      end
    end
  end

  // A host write in the strap cycle wins over the strap
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      periph_cfg_r <= PERIPH_CFG_RST;
    else if (REG_WR && REG_ADDR == PERIPH_CONVERTER_CFG_ADDR)
      periph_cfg_r <= REG_WDATA;
    else if (strap_load)
      periph_cfg_r[PERIPH_STRAP_BIT] <= pstrap_s2_r;
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      proc_cfg_r <= PROC_CFG_RST;
    else if (REG_WR && REG_ADDR == PROC_CONVERTER_CFG_ADDR)
      proc_cfg_r <= REG_WDATA;
    else if (strap_load)
      proc_cfg_r[PROC_STRAP_BIT] <= cstrap_s2_r;
  end

  // Voltage codes are frozen while the regulator runs, so a live rail
  // never steps; the write that enables it may still carry a new code
  always_comb
  begin
    linear_nxt = REG_WDATA;
    if (linear_cfg_r[REG2_EN_BIT])
      linear_nxt[REG2_VOLT_HI:REG2_VOLT_LO] =
        linear_cfg_r[REG2_VOLT_HI:REG2_VOLT_LO];
    if (linear_cfg_r[REG1_EN_BIT])
      linear_nxt[REG1_VOLT_HI:REG1_VOLT_LO] =
        linear_cfg_r[REG1_VOLT_HI:REG1_VOLT_LO];
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      linear_cfg_r <= LINEAR_CFG_RST;
    else if (REG_WR && REG_ADDR == LINEAR_REGULATOR_CFG_ADDR)
      linear_cfg_r <= linear_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe; unmapped reads give zero

  always_comb
  begin
    unique case (REG_ADDR)
      STATUS_LED_ON_TIME_ADDR: rdata_nxt = led_on_r[0];
      STATUS_LED_PERIOD_ADDR: rdata_nxt = led_per_r[0];
      AUX_LED_ON_TIME_ADDR: rdata_nxt = led_on_r[1];
      AUX_LED_PERIOD_ADDR: rdata_nxt = led_per_r[1];
      PERIPH_CONVERTER_CFG_ADDR: rdata_nxt = periph_cfg_r;
      PROC_CONVERTER_CFG_ADDR: rdata_nxt = proc_cfg_r;
      LINEAR_REGULATOR_CFG_ADDR: rdata_nxt = linear_cfg_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink generators

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      tick_cnt_r <= 32'h0;
    else if (tick)
      tick_cnt_r <= 32'h0;
    else
      tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  assign tick = (tick_cnt_r >= 32'(TICK_LEN - 1));

  assign sel[0] = {led_on_r[0][SEL_BIT], led_per_r[0][SEL_BIT]};
  assign sel[1] = {led_on_r[1][SEL_BIT], led_per_r[1][SEL_BIT]};

  // Position restarts outside blink and on any write to that LED's registers,
  // so a new setting always begins in its on phase
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pos_r[0] <= 11'h000;
      pos_r[1] <= 11'h000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (sel[i] != SEL_BLINK || wr_led_on[i] || wr_led_per[i])
          pos_r[i] <= 11'h000;
        else if (tick)
        begin
          if (pos_r[i] >= plc_period_ticks(led_per_r[i][6:0]) - 11'h001)
            pos_r[i] <= 11'h000;
          else
            pos_r[i] <= pos_r[i] + 11'h001;
        end
      end
    end
  end

  always_comb
  begin
    unique case (sel[0])
      SEL_CHARGER: drive[0] = CHG_LED_REQ;
      SEL_BLINK: drive[0] = plc_blink_on(pos_r[0], led_on_r[0][6:0]);
      SEL_OFF: drive[0] = 1'b0;
      SEL_ON: drive[0] = 1'b1;
    endcase
    unique case (sel[1])
      SEL_CHARGER: drive[1] = 1'b0;
      SEL_BLINK: drive[1] = plc_blink_on(pos_r[1], led_on_r[1][6:0]);
      SEL_OFF: drive[1] = 1'b0;
      SEL_ON: drive[1] = 1'b1;
    endcase
  end

  // Open-drain: the pad only ever pulls low
  assign STATUS_LED_OUTPUT_O = 1'b0;
  assign AUX_LED_OUTPUT_O = 1'b0;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      STATUS_LED_OUTPUT_OE <= 1'b0;
      AUX_LED_OUTPUT_OE <= 1'b0;
    end
    else
    begin
      STATUS_LED_OUTPUT_OE <= drive[0];
      AUX_LED_OUTPUT_OE <= drive[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power modes and rail controls

  assign sleep_active = periph_cfg_r[SLEEP_PIN_EN_BIT] && sleep_s2_r;
  assign wait_mode = sleep_active && !periph_cfg_r[SLEEP_KIND_BIT];
  assign lp_mode = sleep_active && periph_cfg_r[SLEEP_KIND_BIT];
  assign proc_off = wait_mode ||
                    (lp_mode && proc_cfg_r[SLEEP_PROC_OFF_BIT]);

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FIXED_FREQ_FORCE <= 1'b0;
      BROWNOUT_LEVEL <= PERIPH_CFG_RST[BROWNOUT_HI:BROWNOUT_LO];
      WAIT_MODE <= 1'b0;
      LOW_POWER_MODE <= 1'b0;
      PERIPH_RAIL_EN <= 1'b1;
      PERIPH_RAIL_DISCHARGE <= 1'b0;
      PERIPH_RAIL_VOLT <= PERIPH_CFG_RST[PERIPH_VOLT_HI:0];
      PROC_RAIL_EN <= 1'b1;
      PROC_RAIL_DISCHARGE <= 1'b0;
      PROC_RAIL_VOLT <= PROC_CFG_RST[PROC_VOLT_HI:PROC_STRAP_BIT];
      MOTOR_BUZZ_SWITCH <= 1'b0;
    end
    else
    begin
      FIXED_FREQ_FORCE <= periph_cfg_r[FIXED_FREQ_BIT];
      BROWNOUT_LEVEL <= periph_cfg_r[BROWNOUT_HI:BROWNOUT_LO];
      WAIT_MODE <= wait_mode;
      LOW_POWER_MODE <= lp_mode;
      PERIPH_RAIL_EN <= !wait_mode;
      PERIPH_RAIL_DISCHARGE <= wait_mode &&
                               periph_cfg_r[PERIPH_DISCH_BIT];
      PERIPH_RAIL_VOLT <= periph_cfg_r[PERIPH_VOLT_HI:0];
      PROC_RAIL_EN <= !proc_off;
      PROC_RAIL_DISCHARGE <= proc_off &&
                             proc_cfg_r[PROC_DISCH_BIT];
      if (lp_mode)
        PROC_RAIL_VOLT <= {1'b0,
          proc_cfg_r[SLEEP_PROC_VOLT_HI:SLEEP_PROC_VOLT_LO]};
      else
        PROC_RAIL_VOLT <= proc_cfg_r[PROC_VOLT_HI:PROC_STRAP_BIT];
      MOTOR_BUZZ_SWITCH <= proc_cfg_r[MOTOR_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      REG1_EN <= LINEAR_CFG_RST[REG1_EN_BIT];
      REG1_REDUCED <= 1'b0;
      REG1_VOLT <= LINEAR_CFG_RST[REG1_VOLT_HI:REG1_VOLT_LO];
      REG2_EN <= LINEAR_CFG_RST[REG2_EN_BIT];
      REG2_REDUCED <= 1'b0;
      REG2_VOLT <= LINEAR_CFG_RST[REG2_VOLT_HI:REG2_VOLT_LO];
    end
    else
    begin
      REG1_EN <= linear_cfg_r[REG1_EN_BIT] &&
                 !(lp_mode && linear_cfg_r[REG1_SLEEP_OFF_BIT]);
      REG1_REDUCED <= linear_cfg_r[REG1_EN_BIT] && lp_mode &&
                      !linear_cfg_r[REG1_SLEEP_OFF_BIT];
      REG1_VOLT <= linear_cfg_r[REG1_VOLT_HI:REG1_VOLT_LO];
      REG2_EN <= linear_cfg_r[REG2_EN_BIT] &&
                 !(lp_mode && linear_cfg_r[REG2_SLEEP_OFF_BIT]);
      REG2_REDUCED <= linear_cfg_r[REG2_EN_BIT] && lp_mode &&
                      !linear_cfg_r[REG2_SLEEP_OFF_BIT];
      REG2_VOLT <= linear_cfg_r[REG2_VOLT_HI:REG2_VOLT_LO];
    end
  end

endmodule : plc_config_regs

// File: verilog/plc_pkg.sv
package plc_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] STATUS_LED_ON_TIME_ADDR = 8'h08;
  localparam logic [7:0] STATUS_LED_PERIOD_ADDR = 8'h09;
  localparam logic [7:0] AUX_LED_ON_TIME_ADDR = 8'h0A;
  localparam logic [7:0] AUX_LED_PERIOD_ADDR = 8'h0B;
  localparam logic [7:0] PERIPH_CONVERTER_CFG_ADDR = 8'h0C;
  localparam logic [7:0] PROC_CONVERTER_CFG_ADDR = 8'h0D;
  localparam logic [7:0] LINEAR_REGULATOR_CFG_ADDR = 8'h0E;

  // Reset values; strap bits are loaded separately after reset
  localparam logic [7:0] LED_REG_RST = 8'h00;
  localparam logic [7:0] PERIPH_CFG_RST = 8'h32;
  localparam logic [7:0] PROC_CFG_RST = 8'h68;
  localparam logic [7:0] LINEAR_CFG_RST = 8'h88;

  // Field positions
  localparam int SEL_BIT = 7;
  localparam int FIXED_FREQ_BIT = 7;
  localparam int BROWNOUT_HI = 6;
  localparam int BROWNOUT_LO = 5;
  localparam int SLEEP_KIND_BIT = 4;
  localparam int SLEEP_PIN_EN_BIT = 3;
  localparam int PERIPH_DISCH_BIT = 2;
  localparam int PERIPH_VOLT_HI = 1;
  localparam int PERIPH_STRAP_BIT = 0;
  localparam int SLEEP_PROC_OFF_BIT = 7;
  localparam int PROC_VOLT_HI = 6;
  localparam int PROC_STRAP_BIT = 4;
  localparam int SLEEP_PROC_VOLT_HI = 3;
  localparam int SLEEP_PROC_VOLT_LO = 2;
  localparam int MOTOR_BIT = 1;
  localparam int PROC_DISCH_BIT = 0;
  localparam int REG2_EN_BIT = 7;
  localparam int REG2_SLEEP_OFF_BIT = 6;
  localparam int REG2_VOLT_HI = 5;
  localparam int REG2_VOLT_LO = 4;
  localparam int REG1_EN_BIT = 3;
  localparam int REG1_SLEEP_OFF_BIT = 2;
  localparam int REG1_VOLT_HI = 1;
  localparam int REG1_VOLT_LO = 0;

  // Blink timing: one tick is the on-time step, period step is ten ticks
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [10:0] TICKS_PER_PERIOD_STEP = 11'h00A;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Pin select decoding
  typedef enum logic [1:0] {
    SEL_CHARGER, SEL_BLINK, SEL_OFF, SEL_ON
  } plc_sel_e;

  // Period length in ticks, count+1 steps of 100 ms
  function automatic logic [10:0] plc_period_ticks(input logic [6:0] f);
    plc_period_ticks = 11'({4'h0, f} + 11'h001) * TICKS_PER_PERIOD_STEP;
  endfunction : plc_period_ticks

  // On phase holds while position is below count+1 ticks of 10 ms
  function automatic logic plc_blink_on(input logic [10:0] pos,
                                         input logic [6:0] f);
    plc_blink_on = pos < ({4'h0, f} + 11'h001);
  endfunction : plc_blink_on

endpackage : plc_pkg

// File: sim/plc_config_regs_checker.sv
`timescale 1ns/1ps
module plc_config_regs_checker (
  // Clock, reset and register port
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  // Watched outputs
  input wire logic FIXED_FREQ_FORCE,
  input wire logic [1:0] BROWNOUT_LEVEL,
  input wire logic WAIT_MODE,
  input wire logic LOW_POWER_MODE,
  input wire logic PERIPH_RAIL_EN,
  input wire logic PERIPH_RAIL_DISCHARGE,
  input wire logic PROC_RAIL_EN,
  input wire logic PROC_RAIL_DISCHARGE,
  input wire logic [2:0] PROC_RAIL_VOLT,
  input wire logic MOTOR_BUZZ_SWITCH,
  input wire logic REG1_EN,
  input wire logic REG1_REDUCED,
  input wire logic [1:0] REG1_VOLT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  a_fixed_freq_bit:
    assert property (REG_WR && REG_ADDR == 8'h0C |->
      ##2 FIXED_FREQ_FORCE == $past(REG_WDATA[7], 2))
      else $error("fixed frequency bit not applied");
  a_brownout_code:
    assert property (REG_WR && REG_ADDR == 8'h0C |->
      ##2 BROWNOUT_LEVEL == $past(REG_WDATA[6:5], 2))
      else $error("brownout level not applied");
  a_motor_follows_bit:
    assert property (REG_WR && REG_ADDR == 8'h0D |->
      ##2 MOTOR_BUZZ_SWITCH == $past(REG_WDATA[1], 2))
      else $error("motor switch not following its bit");
  a_modes_exclusive:
    assert property (!(WAIT_MODE && LOW_POWER_MODE))
      else $error("wait and low-power modes both active");
  a_wait_rails_off:
    assert property (WAIT_MODE [*2] |-> !PERIPH_RAIL_EN && !PROC_RAIL_EN)
      else $error("rail still enabled in wait mode");
  a_periph_discharge_off:
    assert property (PERIPH_RAIL_DISCHARGE |-> !PERIPH_RAIL_EN)
      else $error("peripheral rail discharged while enabled");
  a_proc_discharge_off:
    assert property (PROC_RAIL_DISCHARGE |-> !PROC_RAIL_EN)
      else $error("processor rail discharged while enabled");
  a_sleep_volt_top:
    assert property (LOW_POWER_MODE [*3] |-> PROC_RAIL_VOLT[2] == 1'b0)
      else $error("low-power processor code has top bit set");
  a_reduced_still_on:
    assert property (REG1_REDUCED |-> REG1_EN)
      else $error("reduced regulator reported off");
  a_volt_lock_enabled:
    assert property (REG_WR && REG_ADDR == 8'h0E && REG1_EN &&
      !($past(REG_WR) && $past(REG_ADDR) == 8'h0E) |->
      ##2 REG1_VOLT == $past(REG1_VOLT, 2))
      else $error("regulator voltage changed while enabled");
endmodule : plc_config_regs_checker

bind plc_config_regs plc_config_regs_checker u_chk (.*);

// File: sim/plc_config_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module plc_config_regs_tb_top;
  import plc_pkg::*;
  // Short tick keeps tested blink periods to at most 160 cycles
  localparam int TL = 4;
  logic mclk, nrst, reg_wr, reg_rd, sleep_pin, chg_req, pstrap, cstrap;
  logic [7:0] reg_addr, reg_wdata, rdata, reg_rdata, d;
  logic status_oe, aux_oe, ff, wait_m, lp_m, prd_en, prd_dis, prc_en;
  logic prc_dis, motor, r1_en, r1_red, r2_en, r2_red, w, l, off;
  logic [1:0] bo, prd_v, r1_v, r2_v;
  logic [2:0] prc_v;
  int mismatches, comparisons, a;

  plc_config_regs #(.TICK_LEN(TL)) u_dut (
    .MCLK(mclk), .NRST(nrst), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SLEEP_REQUEST_PIN(sleep_pin), .PERIPH_VOLT_STRAP(pstrap),
    .PROC_VOLT_STRAP(cstrap), .CHG_LED_REQ(chg_req),
    .STATUS_LED_OUTPUT_I(1'b1), .STATUS_LED_OUTPUT_O(),
    .STATUS_LED_OUTPUT_OE(status_oe), .AUX_LED_OUTPUT_I(1'b1),
    .AUX_LED_OUTPUT_O(), .AUX_LED_OUTPUT_OE(aux_oe),
    .FIXED_FREQ_FORCE(ff), .BROWNOUT_LEVEL(bo), .WAIT_MODE(wait_m),
    .LOW_POWER_MODE(lp_m), .PERIPH_RAIL_EN(prd_en),
    .PERIPH_RAIL_DISCHARGE(prd_dis), .PERIPH_RAIL_VOLT(prd_v),
    .PROC_RAIL_EN(prc_en), .PROC_RAIL_DISCHARGE(prc_dis),
    .PROC_RAIL_VOLT(prc_v), .MOTOR_BUZZ_SWITCH(motor), .REG1_EN(r1_en),
    .REG1_REDUCED(r1_red), .REG1_VOLT(r1_v), .REG2_EN(r2_en),
    .REG2_REDUCED(r2_red), .REG2_VOLT(r2_v)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = dt;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  // Extra cycle before sampling: read data is registered
  task automatic rd(input logic [7:0] ad);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = ad;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    rdata = reg_rdata;
  endtask : rd

  function automatic logic oe_of(input int ch);
    oe_of = ch ? aux_oe : status_oe;
  endfunction : oe_of

  function automatic logic [7:0] exp_rst(input int ad);
    exp_rst = (ad == 12) ? 8'h33 : (ad == 13) ? 8'h78 :
              (ad == 14) ? 8'h88 : 8'h00;
  endfunction : exp_rst

  task automatic run_len(input int ch, input logic lvl, output int n);
    n = 0;
    while (oe_of(ch) === lvl && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : run_len

  // Measures a full period that starts on a tick-aligned rise, or 300 cycles held on when on-time fills the period
  task automatic blink(input int ch, input int on, input int per);
    int hi, lo;
    wr(8'(8 + 2 * ch), {1'b0, 7'(on)});
    wr(8'(9 + 2 * ch), {1'b1, 7'(per)});
    repeat (3) @(negedge mclk);
    if (on + 1 >= (per + 1) * 10)
    begin
      hi = 0;
      repeat (300)
      begin
        @(negedge mclk);
        hi += int'(oe_of(ch) === 1'b1);
      end
      `CHK(hi, 300)
    end
    else
    begin
      run_len(ch, 1'b1, hi);
      run_len(ch, 1'b0, lo);
      run_len(ch, 1'b1, hi);
      run_len(ch, 1'b0, lo);
      `CHK(hi, (on + 1) * TL)
      `CHK(hi + lo, (per + 1) * 10 * TL)
    end
  endtask : blink

  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, reg_wr, reg_rd, sleep_pin, chg_req} = 5'h00;
    {pstrap, cstrap} = 2'b11;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(11));
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);
    for (int i = 7; i <= 15; i++)
    begin
      rd(8'(i));
      `CHK(rdata, exp_rst(i))
    end
    `CHK({prd_v, prc_v}, 5'h1F)
    for (int i = 0; i < 16; i++)
    begin
      a = 8 + int'($urandom_range(0, 5));
      d = 8'($urandom);
      wr(8'(a), d);
      rd(8'(a));
      `CHK(rdata, d)
    end
    // Unmapped place: write ignored, reads as zero
    wr(8'h0F, 8'hA5);
    rd(8'h0F);
    `CHK(rdata, 8'h00)
    for (int b = 0; b < 4; b++)
    begin
      d = (8'($urandom) & 8'h87) | 8'(b << 5);
      wr(8'h0C, d);
      repeat (2) @(negedge mclk);
      `CHK({ff, bo}, d[7:5])
      `CHK(prd_v, d[1:0])
    end
    for (int c = 0; c < 8; c++)
    begin
      d = {1'b0, 3'(c), 2'b10, 1'(c), 1'b0};
      wr(8'h0D, d);
      repeat (2) @(negedge mclk);
      `CHK(prc_v, 3'(c))
      `CHK(motor, d[1])
    end
    for (int i = 0; i < 8; i++)
    begin
      off = 1'(i >> 2);
      wr(8'h0C, 8'h06 | 8'((i & 3) << 3));
      wr(8'h0D, {off, 7'h77});
      wr(8'h0E, 8'hC8);
      sleep_pin = 1'b1;
      repeat (6) @(negedge mclk);
      w = (i & 3) == 1;
      l = (i & 3) == 3;
      `CHK({wait_m, lp_m}, {w, l})
      `CHK({prd_en, prd_dis}, {!w, w})
      `CHK(prc_en, !(w | l & off))
      `CHK(prc_dis, w | l & off)
      `CHK(prc_v, l ? 3'b001 : 3'b111)
      `CHK({r1_en, r1_red, r2_en, r2_red}, {1'b1, l, !l, 1'b0})
      sleep_pin = 1'b0;
      repeat (6) @(negedge mclk);
      `CHK({lp_m, prc_v}, 4'h7)
    end
    wr(8'h0E, 8'h88);
    wr(8'h0E, 8'hBB);
    repeat (2) @(negedge mclk);
    `CHK({r2_v, r1_v}, 4'h0)
    // First write clears the enables but keeps the old codes; codes land once disabled
    wr(8'h0E, 8'h37);
    wr(8'h0E, 8'h37);
    repeat (2) @(negedge mclk);
    `CHK({r2_en, r1_en, r2_v, r1_v}, 6'h0F)
    wr(8'h0E, 8'hA9);
    repeat (2) @(negedge mclk);
    `CHK({r2_en, r1_en, r2_v, r1_v}, 6'h39)
    for (int s = 0; s < 4; s++)
    begin
      if (s == 1)
        continue;
      wr(8'h08, {1'(s >> 1), 7'h05});
      wr(8'h09, {1'(s), 7'h02});
      wr(8'h0A, {1'(s >> 1), 7'h05});
      wr(8'h0B, {1'(s), 7'h02});
      for (int k = 0; k < 2; k++)
      begin
        chg_req = 1'(k);
        repeat (4) @(negedge mclk);
        `CHK(status_oe, (s == 0) ? 1'(k) : 1'(s == 3))
        `CHK(aux_oe, 1'(s == 3))
      end
    end
    for (int ch = 0; ch < 2; ch++)
    begin
      blink(ch, 0, 0);
      blink(ch, 9, 0);
      blink(ch, int'($urandom_range(0, 8)), int'($urandom_range(0, 3)));
    end
    wrap_up();
  end
endmodule : plc_config_regs_tb_top
